// [dbr_apb_host.sv]
// file: apb requester model standing in for both software and the external debugger
`timescale 1ns/1ps
`default_nettype none
module dbr_apb_host
	import dbr_pkg::*;
(
	input  wire logic         clk_i,
	input  wire dbr_apb_rsp_t rsp_i,
	output var  dbr_apb_req_t req_o
);
	// idle cycles before each setup; a slow host must still be served
	int idle_gap = 0;

	initial req_o = '0;

	// ******************************************************************
	// one transfer: setup, access, hold until ready, then release
	// ******************************************************************
	task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] rdata, output logic err);
		int n;
		repeat (idle_gap) @(posedge clk_i);
		@(posedge clk_i);
		// offsets only: the region sits on a 4KB-aligned base of zero
		req_o <= '{sel: 1'b1, enable: 1'b0, write: wr, addr: a, wdata: d};
		@(posedge clk_i);
		req_o.enable <= 1'b1;
		n = 0;
		// request held unchanged until ready is sampled high, bounded wait
		do begin
			@(posedge clk_i);
			n++;
		end while (rsp_i.ready !== 1'b1 && n < 16);
		rdata = rsp_i.rdata;
		err   = rsp_i.slverr;
		// a missing ready poisons the answer so the caller's compare fails
		if (rsp_i.ready !== 1'b1) begin
			err = 1'bx;
		end
		// released lines show the inverse so stale values never pass for data
		req_o <= '{sel: 1'b0, enable: 1'b0, write: ~wr, addr: ~a, wdata: ~d};
	endtask : xfer
endmodule : dbr_apb_host
`default_nettype wire

// [dbr_cmp_bank.sv]
// file: bank of comparator value and control words, one memory per kind
`timescale 1ns/1ps
`default_nettype none
module dbr_cmp_bank
	import dbr_pkg::*;
#(
	parameter int DEPTH = 6
) (
	input  wire logic              clk_i,
	input  wire logic              clear_i,
	input  wire logic              we_i,
	input  wire logic              sel_ctrl_i,
	input  wire logic [SLOT_W-1:0] slot_i,
	input  wire logic [31:0]       d_i,
	output var  logic [31:0]       rd_o
);
	typedef struct packed {
		logic [DEPTH-1:0][31:0] value;
		logic [DEPTH-1:0][31:0] ctrl;
		logic [31:0]            rd;
	} dbr_bank_state_t;

	dbr_bank_state_t st;
	dbr_bank_state_t next_st;

	// values hold plain virtual addresses; read data comes out of a register
	always_comb begin
		next_st = st;
		next_st.rd = ZERO_WORD;
		if (clear_i) begin
			next_st = '0;
		end else begin
			if (int'(slot_i) < DEPTH) begin
				next_st.rd = sel_ctrl_i ? st.ctrl[slot_i] : st.value[slot_i];
				if (we_i && sel_ctrl_i) begin
					next_st.ctrl[slot_i] = d_i;
				end else if (we_i) begin
					next_st.value[slot_i] = d_i;
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		st <= next_st;
	end

	assign rd_o = st.rd;
endmodule : dbr_cmp_bank
`default_nettype wire

// [dbr_debug_window.sv]
// file: top of the memory-mapped debug register window behind an apb slave port
`timescale 1ns/1ps
`default_nettype none
module dbr_debug_window
	import dbr_pkg::*;
#(
	parameter logic [31:0] IDENTITY_VAL = 32'h0000_0000, // arbitrary, not a real part code
	parameter int          BKPT_COUNT   = NUM_BKPT,
	parameter int          WPT_COUNT    = NUM_WPT
) (
	input  wire logic          clk_i,
	input  wire logic          reset_i,          // debug-bus reset, both domains
	input  wire logic          power_on_reset_i, // core domain only
	input  wire logic          warm_reset_i,     // touches no debug state
	input  wire dbr_apb_req_t  apb_i,
	input  wire logic          core_powered_down_i,
	input  wire logic          core_compact_state_i,
	input  wire logic          fault_valid_i,
	input  wire logic [31:0]   fault_addr_i,
	input  wire logic [31:0]   c2h_data_i,
	output var  dbr_apb_rsp_t  apb_o,
	output var  dbr_core_cmd_t core_cmd_o,
	output var  logic [31:0]   vector_catch_o,
	output var  logic          sticky_pd_o,
	output var  logic          os_lock_o
);
	// ******************************************************************
	// state
	// ******************************************************************
	typedef struct packed {
		logic          os_lock;
		logic          sw_lock;
		logic          sticky_pd;
		logic [31:0]   ecatch;
		logic [31:0]   pd_ctrl;
		logic [31:0]   os_save;
		logic [31:0]   watch_fault_address;
		logic [31:0]   hcache;
		logic [31:0]   statctl;
		logic [31:0]   h2c;
		dbr_apb_rsp_t  rsp;
		dbr_core_cmd_t cmd;
		logic          bank_rd;
		logic          bank_is_wp;
	} dbr_state_t;

	dbr_state_t st;
	dbr_state_t next_st;

	logic [11:0]       off;
	logic              setup;
	logic              ext_dbg;
	logic              core_reg;
	logic              mapped;
	logic              refuse;
	logic              wr_ok;
	logic              core_clear;
	logic [31:0]       bank_bk_rd;
	logic [31:0]       bank_wp_rd;
	logic [31:0]       vcatch_q;
	logic              vcatch_we;
	logic              bk_we;
	logic              wp_we;
	logic              bk_hit;
	logic              wp_hit;
	logic [SLOT_W-1:0] slot;

	// ******************************************************************
	// decode: word offset, origin and power domain of the target
	// ******************************************************************
	assign off     = {apb_i.addr[11:SLOT_LSB], 2'b00}; // low bits ignored, word access
	assign setup   = apb_i.sel && !apb_i.enable;
	assign ext_dbg = apb_i.addr[EXT_ADDR_BIT];
	assign slot    = apb_i.addr[SLOT_LSB+SLOT_W-1:SLOT_LSB];
	// slots past the comparator count are read-as-zero holes, never refused
	assign bk_hit  = (off[11:6] == OFF_BKV_BASE[11:6] || off[11:6] == OFF_BKC_BASE[11:6])
		&& int'(slot) < BKPT_COUNT;
	assign wp_hit  = (off[11:6] == OFF_WPV_BASE[11:6] || off[11:6] == OFF_WPC_BASE[11:6])
		&& int'(slot) < WPT_COUNT;

	// core-domain registers per the map; identity, catch, run and power stay reachable
	always_comb begin
		core_reg = 1'b0;
		mapped   = 1'b1;
		case (off)
			// core power domain words
			OFF_WATCH_FAULT_ADDRESS_REG,
			OFF_VCATCH,
			OFF_HCACHE,
			OFF_H2C,
			OFF_INJECT,
			OFF_STATCTL,
			OFF_C2H: core_reg = 1'b1;
			// debug power domain words, reachable while the core is off
			OFF_IDENTITY,
			OFF_ECATCH,
			OFF_RUNCTL,
			OFF_OSL_ACCESS,
			OFF_OSL_STATUS,
			OFF_OS_SAVE,
			OFF_PD_CTRL,
			OFF_PD_STATUS,
			OFF_SW_LOCK,
			OFF_LOCK_STAT: mapped = 1'b1;
			default: begin
				core_reg = bk_hit || wp_hit;
				mapped   = bk_hit || wp_hit;
			end
		endcase
	end

	// power-down, sticky flag and os lock all refuse core-domain targets
	assign refuse = core_reg && (core_powered_down_i || st.sticky_pd || st.os_lock);
	// software lock gates writes from software, the lock register itself excepted
	assign wr_ok  = apb_i.write && !refuse && (ext_dbg || !st.sw_lock || off == OFF_SW_LOCK);

	assign core_clear = reset_i || power_on_reset_i;
	assign vcatch_we  = setup && wr_ok && off == OFF_VCATCH;
	assign bk_we      = setup && wr_ok && bk_hit;
	assign wp_we      = setup && wr_ok && wp_hit;

	// ******************************************************************
	// core-domain storage in its own leaves
	// ******************************************************************
	// vector locations are armed as virtual addresses, untranslated
	dbr_word_reg #(.RESET_VAL(ZERO_WORD)) u_vcatch (
		.clk_i   (clk_i),
		.clear_i (core_clear),
		.we_i    (vcatch_we),
		.d_i     (apb_i.wdata),
		.q_o     (vcatch_q)
	);

	// comparators store virtual addresses exactly as written
	dbr_cmp_bank #(.DEPTH(BKPT_COUNT)) u_bkpt (
		.clk_i      (clk_i),
		.clear_i    (core_clear),
		.we_i       (bk_we),
		.sel_ctrl_i (off[6]),
		.slot_i     (slot),
		.d_i        (apb_i.wdata),
		.rd_o       (bank_bk_rd)
	);

	dbr_cmp_bank #(.DEPTH(WPT_COUNT)) u_wpt (
		.clk_i      (clk_i),
		.clear_i    (core_clear),
		.we_i       (wp_we),
		.sel_ctrl_i (off[6]),
		.slot_i     (slot),
		.d_i        (apb_i.wdata),
		.rd_o       (bank_wp_rd)
	);

	// ******************************************************************
	// next state: one apb transfer, answered in the access phase
	// ******************************************************************
	always_comb begin
		next_st = st;
		next_st.cmd.h2c_valid    = 1'b0;
		next_st.cmd.inject_valid = 1'b0;
		next_st.cmd.run_valid    = 1'b0;
		next_st.rsp.ready        = 1'b0;
		next_st.bank_rd          = 1'b0;
		// power-down is sticky; set wins over the clearing read
		if (setup && !apb_i.write && off == OFF_PD_STATUS) begin
			next_st.sticky_pd = 1'b0;
		end
		if (core_powered_down_i) begin
			next_st.sticky_pd = 1'b1;
		end
		if (setup) begin
			next_st.rsp.ready  = 1'b1;
			next_st.rsp.slverr = refuse;
			next_st.rsp.rdata  = ZERO_WORD; // default for holes and refused reads
			next_st.cmd.data   = apb_i.wdata;
			if (!apb_i.write && !refuse) begin
				case (off)
					OFF_IDENTITY:   next_st.rsp.rdata = IDENTITY_VAL;
					OFF_WATCH_FAULT_ADDRESS_REG:   next_st.rsp.rdata = st.watch_fault_address;
					OFF_VCATCH:     next_st.rsp.rdata = vcatch_q;
					OFF_ECATCH:     next_st.rsp.rdata = st.ecatch;
					OFF_HCACHE:     next_st.rsp.rdata = st.hcache;
					OFF_H2C:        next_st.rsp.rdata = st.h2c;
					OFF_STATCTL:    next_st.rsp.rdata = st.statctl;
					OFF_C2H:        next_st.rsp.rdata = c2h_data_i;
					OFF_OSL_STATUS: next_st.rsp.rdata[OSL_BIT] = st.os_lock;
					OFF_OS_SAVE:    next_st.rsp.rdata = st.os_save;
					OFF_PD_CTRL:    next_st.rsp.rdata = st.pd_ctrl;
					OFF_PD_STATUS: begin
						next_st.rsp.rdata[STICKY_PD_BIT] = st.sticky_pd;
						next_st.rsp.rdata[PD_NOW_BIT]    = core_powered_down_i;
					end
					OFF_LOCK_STAT:  next_st.rsp.rdata[SWL_BIT] = st.sw_lock;
					default: begin
						// only live comparator slots read through the banks, next cycle
						next_st.bank_rd    = bk_hit || wp_hit;
						next_st.bank_is_wp = wp_hit;
					end
				endcase
			end
			if (wr_ok) begin
				case (off)
					OFF_WATCH_FAULT_ADDRESS_REG:   next_st.watch_fault_address    = apb_i.wdata;
					OFF_ECATCH:     next_st.ecatch  = apb_i.wdata;
					OFF_HCACHE:     next_st.hcache  = apb_i.wdata;
					OFF_STATCTL:    next_st.statctl = apb_i.wdata;
					OFF_H2C: begin
						next_st.h2c           = apb_i.wdata;
						next_st.cmd.h2c_valid = 1'b1;
					end
					OFF_INJECT:     next_st.cmd.inject_valid = 1'b1;
					OFF_RUNCTL:     next_st.cmd.run_valid    = 1'b1;
					OFF_OSL_ACCESS: next_st.os_lock = (apb_i.wdata == UNLOCK_KEY);
					OFF_OS_SAVE:    next_st.os_save = apb_i.wdata;
					OFF_PD_CTRL:    next_st.pd_ctrl = apb_i.wdata;
					OFF_SW_LOCK:    next_st.sw_lock = (apb_i.wdata != UNLOCK_KEY);
					default:        next_st.os_save = next_st.os_save; // holes ignore writes
				endcase
			end
		end
		// fault capture after the bus write, so hardware wins a same-cycle clash
		if (fault_valid_i) begin
			next_st.watch_fault_address = fault_addr_i + (core_compact_state_i ? WATCH_FAULT_ADDRESS_OFS_NARROW
				: WATCH_FAULT_ADDRESS_OFS_WIDE);
		end
		// core-domain words fall back on power-on reset, debug-domain ones persist
		if (power_on_reset_i) begin
			next_st.watch_fault_address    = ZERO_WORD;
			next_st.hcache  = ZERO_WORD;
			next_st.statctl = ZERO_WORD;
			next_st.h2c     = ZERO_WORD;
		end
		// warm reset is deliberately not used: a live session must survive it
	end

	// ******************************************************************
	// registers; the slave itself lives on the always-on debug reset
	// ******************************************************************
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// bank reads are one cycle later, so their word is merged after the register
	always_comb begin
		apb_o = st.rsp;
		if (st.bank_rd) begin
			// the other bank also reads its slot, so pick one, never or them
			apb_o.rdata = st.bank_is_wp ? bank_wp_rd : bank_bk_rd;
		end
	end
	assign core_cmd_o     = st.cmd;
	assign vector_catch_o = vcatch_q;
	assign sticky_pd_o    = st.sticky_pd;
	assign os_lock_o      = st.os_lock;

	// ******************************************************************
	// checks
	// ******************************************************************
	// all checks sit in the debug domain; the debug-bus reset masks them
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);

	refuse_err_a: assert property (setup && refuse |=> apb_o.ready && apb_o.slverr)
		else $error("refused access not answered with error");
	pd_refuse_a: assert property (setup && core_reg && core_powered_down_i |=> apb_o.slverr)
		else $error("core-domain access accepted while powered down");
	oslock_abort_a: assert property (setup && core_reg && st.os_lock |=> apb_o.slverr)
		else $error("os lock did not abort access");
	sticky_hold_a: assert property (st.sticky_pd && !(setup && !apb_i.write
		&& off == OFF_PD_STATUS) |=> st.sticky_pd)
		else $error("sticky power-down cleared without status read");
	swlock_wi_a: assert property (setup && apb_i.write && st.sw_lock && !ext_dbg
		&& off == OFF_ECATCH |=> $stable(st.ecatch))
		else $error("locked software write took effect");
	watch_fault_address_ofs_a: assert property (fault_valid_i && !core_compact_state_i && !power_on_reset_i
		|=> st.watch_fault_address == $past(fault_addr_i) + WATCH_FAULT_ADDRESS_OFS_WIDE)
		else $error("fault address offset wrong");
	hole_zero_a: assert property (setup && !apb_i.write && !mapped |=> apb_o.rdata == ZERO_WORD)
		else $error("reserved offset read not zero");
	single_xfer_a: assert property (setup |=> apb_o.ready ##1 !apb_o.ready)
		else $error("transfer not one cycle of ready");
	por_keep_a: assert property (power_on_reset_i |=> $stable(st.ecatch) && $stable(st.os_lock))
		else $error("power-on reset disturbed debug domain");
	vc_clear_a: assert property (power_on_reset_i |=> vcatch_q == ZERO_WORD)
		else $error("vector catch survived power-on reset");

	// ******************************************************************
	// checks on resets, locks, the write path, the sticky power-down flag and fault capture
	// ******************************************************************
	warm_keep_a: assert property (warm_reset_i && !setup && !power_on_reset_i
		&& !fault_valid_i |=> $stable(vcatch_q) && $stable(st.ecatch) && $stable(st.os_lock))
		else $error("warm reset disturbed debug state");
	por_clear_a: assert property (power_on_reset_i |=> st.watch_fault_address == ZERO_WORD
		&& st.hcache == ZERO_WORD && st.h2c == ZERO_WORD)
		else $error("core-domain word survived power-on reset");
	ext_write_a: assert property (setup && apb_i.write && ext_dbg && off == OFF_ECATCH
		|=> st.ecatch == $past(apb_i.wdata))
		else $error("external debugger write was lost");
	refuse_keep_a: assert property (setup && refuse && apb_i.write && !power_on_reset_i
		|=> $stable(vcatch_q) && $stable(st.hcache))
		else $error("refused write took effect");
	h2c_word_a: assert property (core_cmd_o.h2c_valid && !$past(power_on_reset_i)
		|-> core_cmd_o.data == st.h2c)
		else $error("host data strobe without its word");
	pd_ecatch_a: assert property (setup && apb_i.write && core_powered_down_i
		&& off == OFF_ECATCH && (ext_dbg || !st.sw_lock) |=> !apb_o.slverr
		&& st.ecatch == $past(apb_i.wdata))
		else $error("debug-domain write refused while core is off");
	sticky_set_a: assert property (core_powered_down_i |=> st.sticky_pd)
		else $error("power-down not latched in sticky flag");
	fault_narrow_a: assert property (fault_valid_i && core_compact_state_i
		&& !power_on_reset_i |=> st.watch_fault_address == $past(fault_addr_i) + WATCH_FAULT_ADDRESS_OFS_NARROW)
		else $error("compact-state fault offset wrong");
	hole_write_a: assert property (setup && apb_i.write && !mapped && !power_on_reset_i
		&& !fault_valid_i |=> $stable(st.watch_fault_address) && $stable(st.ecatch) && $stable(st.os_save)
		&& $stable(st.pd_ctrl) && $stable(st.sw_lock) && $stable(st.os_lock) && $stable(vcatch_q))
		else $error("reserved offset write changed state");

	cov_refused_c: cover property (setup && refuse);
	cov_pd_read_c: cover property (st.sticky_pd ##1 setup && off == OFF_PD_STATUS);
	cov_ext_write_c: cover property (setup && apb_i.write && st.sw_lock && ext_dbg);
	cov_bank_read_c: cover property (st.bank_rd && !apb_o.slverr);
	cov_fault_c: cover property (fault_valid_i && core_compact_state_i);
endmodule : dbr_debug_window
`default_nettype wire

// [dbr_debug_window_tb.sv]
// file: self-checking testbench of the debug register window
`timescale 1ns/1ps
`default_nettype none
module dbr_debug_window_tb
	import dbr_pkg::*;
;
	localparam logic [31:0] ID_VAL  = 32'h1357_2468; // arbitrary, names no real part
	localparam logic [31:0] C2H_VAL = 32'hCAFE_0042;
	logic          clk_i        = 1'b0;
	logic          reset_i      = 1'b1;
	logic          por_i        = 1'b0;
	logic          warm_i       = 1'b0;
	logic          pd_i         = 1'b0;
	logic          compact_i    = 1'b0;
	logic          fv_i         = 1'b0;
	logic [31:0]   faddr_i      = 32'h0;
	logic          src_ext      = 1'b0;
	logic [2:0]    cmd_seen     = 3'h0;
	logic [31:0]   cmd_data     = 32'h0;
	dbr_apb_req_t  apb_i;
	dbr_apb_rsp_t  apb_o;
	dbr_core_cmd_t core_cmd_o;
	logic [31:0]   vc_o;
	logic          sticky_o;
	logic          osl_o;
	int            fail_count   = 0;
	int            compares     = 0;
	int            cycles       = 0;

	always #4 clk_i = ~clk_i;

	dbr_debug_window #(.IDENTITY_VAL(ID_VAL)) dbr_debug_window_i (
		.clk_i(clk_i), .reset_i(reset_i), .power_on_reset_i(por_i), .warm_reset_i(warm_i),
		.apb_i(apb_i), .core_powered_down_i(pd_i), .core_compact_state_i(compact_i),
		.fault_valid_i(fv_i), .fault_addr_i(faddr_i), .c2h_data_i(C2H_VAL), .apb_o(apb_o),
		.core_cmd_o(core_cmd_o), .vector_catch_o(vc_o), .sticky_pd_o(sticky_o),
		.os_lock_o(osl_o));
	dbr_apb_host dbr_apb_host_i (.clk_i(clk_i), .rsp_i(apb_o), .req_o(apb_i));

	// ******************************************************************
	// monitors, checks and closing
	// ******************************************************************
	// one-cycle command strobes are latched so a slow check cannot miss them
	always @(posedge clk_i) begin
		if (core_cmd_o.h2c_valid | core_cmd_o.inject_valid | core_cmd_o.run_valid) begin
			cmd_seen <= {core_cmd_o.h2c_valid, core_cmd_o.inject_valid, core_cmd_o.run_valid};
			cmd_data <= core_cmd_o.data;
		end
	end

	// hang guard: far beyond the 57 transfers of the run
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 6000) begin
			fail_count++;
			$display("ERROR %0t run did not finish", $time);
			print_verdict();
		end
	end

	task automatic print_verdict();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : print_verdict

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %0t %s: seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check

	task automatic wr(input logic [11:0] ofs, input logic [31:0] d, input logic err);
		logic [31:0] r;
		logic        e;
		dbr_apb_host_i.xfer(1'b1, {src_ext, 19'h0, ofs}, d, r, e);
		check({31'h0, e}, {31'h0, err}, "write response");
	endtask : wr

	task automatic rd(input logic [11:0] ofs, input logic [31:0] exp, input logic err);
		logic [31:0] r;
		logic        e;
		dbr_apb_host_i.xfer(1'b0, {src_ext, 19'h0, ofs}, 32'h0, r, e);
		check(r, exp, "read data");
		check({31'h0, e}, {31'h0, err}, "read response");
	endtask : rd

	// ******************************************************************
	// scenarios
	// ******************************************************************
	task automatic t_map();
		logic [11:0] holes [8] = '{12'h004, 12'h014, 12'h020, 12'h02C, 12'h094, 12'h118,
			12'h30C, 12'h318};
		rd(OFF_IDENTITY, ID_VAL, 1'b0);
		wr(12'h030, 32'hFFFF_FFFF, 1'b0);
		for (int i = 0; i < 8; i++) rd(holes[i], 32'h0, 1'b0);
		wr(OFF_VCATCH, 32'hA5A5_0003, 1'b0);
		@(negedge clk_i);
		check(vc_o, 32'hA5A5_0003, "vector catch out");
		wr(OFF_BKV_BASE, 32'h0000_8000, 1'b0);
		wr(OFF_BKV_BASE + 12'h014, 32'hFFFF_FFFC, 1'b0);
		wr(OFF_WPC_BASE + 12'h004, 32'h0000_01E7, 1'b0);
		rd(OFF_BKV_BASE, 32'h0000_8000, 1'b0);
		rd(OFF_BKV_BASE + 12'h014, 32'hFFFF_FFFC, 1'b0);
		rd(OFF_WPC_BASE + 12'h004, 32'h0000_01E7, 1'b0);
		rd(OFF_VCATCH, 32'hA5A5_0003, 1'b0);
	endtask : t_map

	task automatic t_cmd();
		wr(OFF_H2C, 32'h1111_2222, 1'b0);
		@(negedge clk_i);
		check({29'h0, cmd_seen}, 32'h4, "host data strobe");
		check(cmd_data, 32'h1111_2222, "host data word");
		wr(OFF_INJECT, 32'h3333_4444, 1'b0);
		@(negedge clk_i);
		check({29'h0, cmd_seen}, 32'h2, "inject strobe");
		wr(OFF_RUNCTL, 32'h0000_0002, 1'b0);
		@(negedge clk_i);
		check({29'h0, cmd_seen}, 32'h1, "run strobe");
		rd(OFF_C2H, C2H_VAL, 1'b0);
	endtask : t_cmd

	// fault address plus state offset, wide then compact state
	task automatic t_fault();
		for (int c = 0; c < 2; c++) begin
			@(posedge clk_i);
			compact_i <= c[0];
			fv_i      <= 1'b1;
			faddr_i   <= 32'h0000_4000 + c;
			@(posedge clk_i);
			fv_i <= 1'b0;
			rd(OFF_WATCH_FAULT_ADDRESS_REG, 32'h0000_4000 + c + (c[0] ? WATCH_FAULT_ADDRESS_OFS_NARROW : WATCH_FAULT_ADDRESS_OFS_WIDE),
				1'b0);
		end
	endtask : t_fault

	task automatic t_power();
		@(posedge clk_i);
		pd_i <= 1'b1;
		rd(OFF_VCATCH, 32'h0, 1'b1);
		wr(OFF_VCATCH, 32'h0000_00FF, 1'b1);
		wr(OFF_ECATCH, 32'h0000_0002, 1'b0);
		rd(OFF_IDENTITY, ID_VAL, 1'b0);
		rd(OFF_PD_STATUS, 32'h0000_0003, 1'b0);
		@(posedge clk_i);
		pd_i <= 1'b0;
		@(negedge clk_i);
		check({31'h0, sticky_o}, 32'h1, "sticky kept");
		rd(OFF_VCATCH, 32'h0, 1'b1);
		rd(OFF_PD_STATUS, 32'h0000_0002, 1'b0);
		rd(OFF_VCATCH, 32'hA5A5_0003, 1'b0);
		rd(OFF_ECATCH, 32'h0000_0002, 1'b0);
	endtask : t_power

	task automatic t_oslock();
		wr(OFF_OSL_ACCESS, UNLOCK_KEY, 1'b0);
		@(negedge clk_i);
		check({31'h0, osl_o}, 32'h1, "os lock out");
		rd(OFF_OSL_STATUS, 32'h0000_0002, 1'b0);
		wr(OFF_HCACHE, 32'h0000_0007, 1'b1);
		rd(OFF_BKV_BASE, 32'h0, 1'b1);
		rd(OFF_ECATCH, 32'h0000_0002, 1'b0);
		wr(OFF_OSL_ACCESS, 32'h0, 1'b0);
		rd(OFF_HCACHE, 32'h0, 1'b0);
	endtask : t_oslock

	task automatic t_swlock();
		wr(OFF_SW_LOCK, 32'h0, 1'b0);
		rd(OFF_LOCK_STAT, 32'h0000_0002, 1'b0);
		wr(OFF_ECATCH, 32'h0000_0005, 1'b0);
		rd(OFF_ECATCH, 32'h0000_0002, 1'b0);
		src_ext = 1'b1;
		wr(OFF_ECATCH, 32'h0000_0005, 1'b0);
		rd(OFF_ECATCH, 32'h0000_0005, 1'b0);
		src_ext = 1'b0;
		wr(OFF_SW_LOCK, UNLOCK_KEY, 1'b0);
		rd(OFF_LOCK_STAT, 32'h0, 1'b0);
	endtask : t_swlock

	task automatic t_resets();
		wr(OFF_VCATCH, 32'h0000_00C3, 1'b0);
		wr(OFF_BKC_BASE, 32'h0000_01E7, 1'b0);
		@(posedge clk_i);
		warm_i <= 1'b1;
		@(posedge clk_i);
		warm_i <= 1'b0;
		rd(OFF_VCATCH, 32'h0000_00C3, 1'b0);
		@(posedge clk_i);
		por_i <= 1'b1;
		@(posedge clk_i);
		por_i <= 1'b0;
		rd(OFF_VCATCH, 32'h0, 1'b0);
		rd(OFF_BKC_BASE, 32'h0, 1'b0);
		rd(OFF_ECATCH, 32'h0000_0005, 1'b0);
		wr(OFF_OSL_ACCESS, UNLOCK_KEY, 1'b0);
		@(posedge clk_i);
		reset_i <= 1'b1;
		@(posedge clk_i);
		reset_i <= 1'b0;
		rd(OFF_ECATCH, 32'h0, 1'b0);
		rd(OFF_OSL_STATUS, 32'h0, 1'b0);
	endtask : t_resets

	// ******************************************************************
	// main sequence
	// ******************************************************************
	initial begin
		repeat (8) @(posedge clk_i);
		reset_i <= 1'b0;
		t_map();
		t_cmd();
		t_fault();
		dbr_apb_host_i.idle_gap = 3;
		t_power();
		t_oslock();
		t_swlock();
		t_resets();
		print_verdict();
	end
endmodule : dbr_debug_window_tb
`default_nettype wire

// [dbr_pkg.sv]
// package: register map, field positions, reset values and carrier types of the debug window
package dbr_pkg;

	// ******************************************************************
	// register offsets (byte addresses within the 4KB region)
	// ******************************************************************
	localparam logic [11:0] OFF_IDENTITY   = 12'h000;
	localparam logic [11:0] OFF_WATCH_FAULT_ADDRESS_REG   = 12'h018;
	localparam logic [11:0] OFF_VCATCH     = 12'h01C;
	localparam logic [11:0] OFF_ECATCH     = 12'h024;
	localparam logic [11:0] OFF_HCACHE     = 12'h028;
	localparam logic [11:0] OFF_H2C        = 12'h080;
	localparam logic [11:0] OFF_INJECT     = 12'h084;
	localparam logic [11:0] OFF_STATCTL    = 12'h088;
	localparam logic [11:0] OFF_C2H        = 12'h08C;
	localparam logic [11:0] OFF_RUNCTL     = 12'h090;
	localparam logic [11:0] OFF_BKV_BASE   = 12'h100;
	localparam logic [11:0] OFF_BKC_BASE   = 12'h140;
	localparam logic [11:0] OFF_WPV_BASE   = 12'h180;
	localparam logic [11:0] OFF_WPC_BASE   = 12'h1C0;
	localparam logic [11:0] OFF_OSL_ACCESS = 12'h300;
	localparam logic [11:0] OFF_OSL_STATUS = 12'h304;
	localparam logic [11:0] OFF_OS_SAVE    = 12'h308;
	localparam logic [11:0] OFF_PD_CTRL    = 12'h310;
	localparam logic [11:0] OFF_PD_STATUS  = 12'h314;
	localparam logic [11:0] OFF_SW_LOCK    = 12'hFB0;
	localparam logic [11:0] OFF_LOCK_STAT  = 12'hFB4;
	localparam logic [11:0] OFF_MGMT_FIRST = 12'hF04;

	// ******************************************************************
	// counts, fields and values
	// ******************************************************************
	localparam int          NUM_BKPT        = 6;
	localparam int          NUM_WPT         = 2;
	localparam int          SLOT_LSB        = 2;
	localparam int          SLOT_W          = 4;
	localparam logic [31:0] UNLOCK_KEY      = 32'hC5ACCE55;
	localparam logic [31:0] ZERO_WORD       = 32'h00000000;
	localparam logic [31:0] WATCH_FAULT_ADDRESS_OFS_WIDE   = 32'h00000008;
	localparam logic [31:0] WATCH_FAULT_ADDRESS_OFS_NARROW = 32'h00000004;
	localparam int          OSL_BIT         = 1;
	localparam int          STICKY_PD_BIT   = 1;
	localparam int          PD_NOW_BIT      = 0;
	localparam int          SWL_BIT         = 1;
	localparam int          EXT_ADDR_BIT    = 31;

	// apb request as seen by the slave
	typedef struct packed {
		logic        sel;
		logic        enable;
		logic        write;
		logic [31:0] addr;
		logic [31:0] wdata;
	} dbr_apb_req_t;

	// apb answer
	typedef struct packed {
		logic        ready;
		logic        slverr;
		logic [31:0] rdata;
	} dbr_apb_rsp_t;

	// one-cycle strobes towards the core
	typedef struct packed {
		logic        h2c_valid;
		logic        inject_valid;
		logic        run_valid;
		logic [31:0] data;
	} dbr_core_cmd_t;

endpackage : dbr_pkg

// [dbr_word_reg.sv]
// file: one 32-bit register word with its own reset and write strobe
`timescale 1ns/1ps
`default_nettype none
module dbr_word_reg
	import dbr_pkg::*;
#(
	parameter logic [31:0] RESET_VAL = 32'h00000000
) (
	input  wire logic        clk_i,
	input  wire logic        clear_i,
	input  wire logic        we_i,
	input  wire logic [31:0] d_i,
	output var  logic [31:0] q_o
);
	typedef struct packed {
		logic [31:0] value;
	} dbr_word_state_t;

	dbr_word_state_t st;
	dbr_word_state_t next_st;

	// the clear comes from whichever reset owns this word's power domain
	always_comb begin
		next_st = st;
		if (clear_i) begin
			next_st.value = RESET_VAL;
		end else if (we_i) begin
			next_st.value = d_i;
		end
	end

	always_ff @(posedge clk_i) begin
		st <= next_st;
	end

	assign q_o = st.value;
endmodule : dbr_word_reg
`default_nettype wire
